// ---- pkg/mcjd_pkg.sv ----
// package: constants and types for the microcore conditional jump decoder
package mcjd_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int PC_W     = 10;   // code ram address width
  localparam int INSTR_W  = 16;
  localparam int COND_W   = 6;
  localparam int OFS_W    = 5;
  localparam int NFLAG    = 16;
  localparam int NJREG    = 2;    // jump register set size

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int COND_LSB   = 5;
  localparam int OFS_LSB    = 0;
  localparam int CORE_BIT   = 4;
  localparam int JREG_BIT   = 3;

  // opcode patterns
  localparam logic [4:0]  REL_OPC     = 5'h00;
  localparam logic [10:0] ABS_OPC_HI  = 11'h1CC;   // bits 15..5
  localparam logic [2:0]  ABS_OPC_LO  = 3'h5;      // bits 2..0

  // ***************************************************************
  // condition code groups
  // ***************************************************************
  localparam logic [5:0] C_TC1      = 6'h20;
  localparam logic [5:0] C_START_LO = 6'h24;
  localparam logic [5:0] C_START_HI = 6'h25;
  localparam logic [5:0] C_SCV_LO   = 6'h26;
  localparam logic [5:0] C_SCS_LO   = 6'h29;
  localparam logic [5:0] C_SCV_HI   = 6'h2C;
  localparam logic [5:0] C_ALU_DONE = 6'h2F;
  localparam logic [5:0] C_VB_HI    = 6'h30;
  localparam logic [5:0] C_VB_LO    = 6'h31;
  localparam logic [5:0] C_CUR_HI   = 6'h32;
  localparam logic [5:0] C_CUR_LO   = 6'h38;
  localparam logic [5:0] C_OWN_HI   = 6'h3E;
  localparam logic [5:0] C_OWN_LO   = 6'h3F;

  // reset values
  localparam logic [9:0] PC_RESET   = 10'h000;

  typedef enum logic [1:0] {
    MCJD_NONE,
    MCJD_REL,
    MCJD_ABS
  } mcjd_kind_t;

endpackage : mcjd_pkg

// ---- rtl/mcjd_cond_mux.sv ----
// selects one of 64 jump conditions from the condition code
module mcjd_cond_mux (
  input  wire logic [5:0]  cond_code,
  input  wire logic [15:0] flags,
  input  wire logic [3:0]  terminal_count,
  input  wire logic        start_in,
  input  wire logic [2:0]  shortcut_drain_source,
  input  wire logic [2:0]  shortcut_source,
  input  wire logic        alu_done,
  input  wire logic        boost_voltage_high,
  input  wire logic [5:0]  current_feedback,
  input  wire logic        own_current_feedback,
  output logic             cond_true
);

  logic [2:0] sub;

  // pure mux; flags are already sampled in the core domain
  always_comb
  begin
    cond_true = 1'b0;
    sub       = 3'd0;
    if (cond_code[5] == 1'b0)
      cond_true = flags[cond_code[3:0]] == cond_code[4];
    else if (cond_code < mcjd_pkg::C_START_LO)
      cond_true = terminal_count[cond_code[1:0]];
    else if (cond_code == mcjd_pkg::C_START_LO)
      cond_true = ~start_in;
    else if (cond_code == mcjd_pkg::C_START_HI)
      cond_true = start_in;
    else if (cond_code < mcjd_pkg::C_SCS_LO)
    begin
      sub       = 3'(cond_code - mcjd_pkg::C_SCV_LO);
      cond_true = ~shortcut_drain_source[sub[1:0]];
    end
    else if (cond_code < mcjd_pkg::C_SCV_HI)
    begin
      sub       = 3'(cond_code - mcjd_pkg::C_SCS_LO);
      cond_true = ~shortcut_source[sub[1:0]];
    end
    else if (cond_code < mcjd_pkg::C_ALU_DONE)
    begin
      sub       = 3'(cond_code - mcjd_pkg::C_SCV_HI);
      cond_true = shortcut_drain_source[sub[1:0]];
    end
    else if (cond_code == mcjd_pkg::C_ALU_DONE)
      cond_true = alu_done;
    else if (cond_code == mcjd_pkg::C_VB_HI)
      cond_true = boost_voltage_high;
    else if (cond_code == mcjd_pkg::C_VB_LO)
      cond_true = ~boost_voltage_high;
    else if (cond_code < mcjd_pkg::C_CUR_LO)
    begin
      sub       = 3'(cond_code - mcjd_pkg::C_CUR_HI);
      cond_true = current_feedback[sub];
    end
    else if (cond_code < mcjd_pkg::C_OWN_HI)
    begin
      sub       = 3'(cond_code - mcjd_pkg::C_CUR_LO);
      cond_true = ~current_feedback[sub];
    end
    else if (cond_code == mcjd_pkg::C_OWN_HI)
      cond_true = own_current_feedback;
    else
      cond_true = ~own_current_feedback;
  end

endmodule : mcjd_cond_mux

// ---- rtl/mcjd_decode.sv ----
// classifies an instruction word as relative, absolute or other
module mcjd_decode (
  input  wire logic [15:0]         instr,
  output mcjd_pkg::mcjd_kind_t     kind
);

  // fixed-bit match; every other opcode falls through to none
  always_comb
  begin
    if (instr[15:11] == mcjd_pkg::REL_OPC)
      kind = mcjd_pkg::MCJD_REL;
    else if (instr[15:5] == mcjd_pkg::ABS_OPC_HI &&
             instr[2:0] == mcjd_pkg::ABS_OPC_LO)
      kind = mcjd_pkg::MCJD_ABS;
    else
      kind = mcjd_pkg::MCJD_NONE;
  end

endmodule : mcjd_decode

// ---- rtl/mcjd_top.sv ----
// conditional jump decode and program counter update for one microcore
// Notes on behaviour
// - relative jump with true condition loads pc with own address plus offset
// - offset is five-bit two's complement, range minus sixteen to fifteen
// - relative jump has bits 15..11 zero, condition 10..5, offset 4..0
// - codes 0..15 true on flag low, 16..31 on flag high
// - terminal counts 1..4, start low/high, alu operation done
// - shortcut drain-source low, source low, drain-source high groups
// - boost voltage high/low, current feedbacks high then low
// - code 62 own current feedback high, 63 own feedback low
// - absolute jump with true core match loads selected jump register
// - bit 3 picks one jump register holding any absolute address
// - core selector 0 matches core zero, 1 matches core one
// - absolute jump fixed bits 15..5 and 2..0, bit4 core, bit3 register
module mcjd_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic        core_id,
  input  wire logic [9:0]  jump_register_set_0,
  input  wire logic [9:0]  jump_register_set_1,
  input  wire logic [15:0] flags,
  input  wire logic [3:0]  terminal_count,
  input  wire logic        start_in,
  input  wire logic [2:0]  shortcut_drain_source,
  input  wire logic [2:0]  shortcut_source,
  input  wire logic        alu_done,
  input  wire logic        boost_voltage_high,
  input  wire logic [5:0]  current_feedback,
  input  wire logic        own_current_feedback,
  output logic [9:0]       program_counter,
  output logic             jump_taken
);

  // ***************************************************************
  // decode
  // ***************************************************************
  mcjd_pkg::mcjd_kind_t kind;
  logic                 cond_true;
  logic                 core_zero_match;
  logic                 core_one_match;
  logic                 core_match;
  logic [9:0]           rel_target;
  logic [9:0]           abs_target;
  logic [9:0]           next_program_counter;
  logic                 next_jump_taken;

  mcjd_decode mcjd_decode_inst (
    .instr (instr),
    .kind  (kind)
  );

  mcjd_cond_mux mcjd_cond_mux_inst (
    .cond_code             (instr[mcjd_pkg::COND_LSB +: mcjd_pkg::COND_W]),
    .flags                 (flags),
    .terminal_count        (terminal_count),
    .start_in              (start_in),
    .shortcut_drain_source (shortcut_drain_source),
    .shortcut_source       (shortcut_source),
    .alu_done              (alu_done),
    .boost_voltage_high    (boost_voltage_high),
    .current_feedback      (current_feedback),
    .own_current_feedback  (own_current_feedback),
    .cond_true             (cond_true)
  );

  // ***************************************************************
  // targets
  // ***************************************************************
  // sign extension lets the pc wrap around the code ram edges
  assign rel_target = program_counter +
                      {{5{instr[4]}}, instr[4:0]};

  // register select; bit 3 indexes the two-entry set
  assign abs_target = instr[mcjd_pkg::JREG_BIT] ?
                      jump_register_set_1 :
                      jump_register_set_0;

  assign core_zero_match = ~instr[mcjd_pkg::CORE_BIT] & ~core_id;
  assign core_one_match  =  instr[mcjd_pkg::CORE_BIT] &  core_id;
  assign core_match      = core_zero_match | core_one_match;

  // next-pc selection; non-jump words simply step
  always_comb
  begin
    next_program_counter = program_counter + 10'h001;
    next_jump_taken      = 1'b0;
    case (kind)
      mcjd_pkg::MCJD_REL:
      begin
        if (cond_true)
        begin
          next_program_counter = rel_target;
          next_jump_taken      = 1'b1;
        end
      end
      mcjd_pkg::MCJD_ABS:
      begin
        if (core_match)
        begin
          next_program_counter = abs_target;
          next_jump_taken      = 1'b1;
        end
      end
      default:
      begin
        next_jump_taken = 1'b0;
      end
    endcase
  end

  // ***************************************************************
  // state
  // ***************************************************************
  // pc only moves on an executed word, so stalls hold it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      program_counter <= mcjd_pkg::PC_RESET;
    else if (instr_valid)
      program_counter <= next_program_counter;
  end

  // one-cycle marker that the last executed word redirected the pc
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      jump_taken <= 1'b0;
    else
      jump_taken <= instr_valid & next_jump_taken;
  end

endmodule : mcjd_top

// ---- testbench/mcjd_asserts.sv ----
// checker: port-level assertions for the conditional jump decoder
module mcjd_checker (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        instr_valid,
  input wire logic [15:0] instr,
  input wire logic        core_id,
  input wire logic [9:0]  jump_register_set_0,
  input wire logic [9:0]  jump_register_set_1,
  input wire logic [15:0] flags,
  input wire logic [3:0]  terminal_count,
  input wire logic        own_current_feedback,
  input wire logic [9:0]  program_counter,
  input wire logic        jump_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  // word classes, qualified by instr_valid
  wire logic rel   = instr_valid && instr[15:11] == 5'h00;
  wire logic abs_w = instr_valid && instr[15:5] == 11'h1cc &&
                     instr[2:0] == 3'h5;
  wire logic other = instr_valid && instr[15:11] != 5'h00 && !abs_w;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // ****************************
  // assertions
  // ****************************
  // target arithmetic only; the condition checks below pin the choice for flag, count and own-feedback codes
  a_rel_target: assert property (
    rel |=> program_counter == $past(program_counter) +
      (jump_taken ? {{5{$past(instr[4])}}, $past(instr[4:0])} : 10'h001))
    else $error("relative target wrong");
  a_abs_match: assert property (
    abs_w && instr[4] == core_id |=> jump_taken &&
      program_counter ==
      $past(instr[3] ? jump_register_set_1 : jump_register_set_0))
    else $error("absolute jump not taken to register");
  a_abs_miss: assert property (
    abs_w && instr[4] != core_id |=> !jump_taken &&
      program_counter == $past(program_counter) + 10'h001)
    else $error("core miss jumped");
  a_other_word: assert property (
    other |=> !jump_taken &&
      program_counter == $past(program_counter) + 10'h001)
    else $error("plain word jumped");
  a_idle_hold: assert property (
    !instr_valid |=> $stable(program_counter) && !jump_taken)
    else $error("pc moved while idle");
  a_flag_low: assert property (
    rel && instr[10:9] == 2'b00 |=> jump_taken != $past(flags[instr[8:5]]))
    else $error("flag low condition wrong");
  a_flag_high: assert property (
    rel && instr[10:9] == 2'b01 |=> jump_taken == $past(flags[instr[8:5]]))
    else $error("flag high condition wrong");
  a_tc_cond: assert property (
    rel && instr[10:7] == 4'b1000 |=>
      jump_taken == $past(terminal_count[instr[6:5]]))
    else $error("count condition wrong");
  a_own_cond: assert property (
    rel && instr[10:6] == 5'b11111 |=>
      jump_taken == $past(own_current_feedback ^ instr[5]))
    else $error("own feedback wrong");
  // main scenarios reached
  c_rel_taken: cover property (rel ##1 jump_taken);
  c_abs_taken: cover property (abs_w ##1 jump_taken);
  c_abs_miss: cover property (abs_w ##1 !jump_taken);
  c_idle: cover property (!instr_valid ##1 !instr_valid);
endmodule : mcjd_checker

bind mcjd_top mcjd_checker mcjd_checker_inst (
  .clk_sys,
  .rst_b,
  .instr_valid,
  .instr,
  .core_id,
  .jump_register_set_0,
  .jump_register_set_1,
  .flags,
  .terminal_count,
  .own_current_feedback,
  .program_counter,
  .jump_taken
);

// ---- testbench/mcjd_tb_top.sv ----
// testbench: self-checking scenarios for the conditional jump decoder
module mcjd_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_b, instr_valid, core_id;
  logic [15:0] instr;
  logic [9:0]  jr0, jr1, mpc;
  logic [35:0] v;  // condition levels, flags in the top sixteen bits
  wire logic [9:0] program_counter;
  wire logic       jump_taken;
  int          n_fail = 0, n_compared = 0, cyc = 0;
  mcjd_top mcjd_top_inst (.clk_sys, .rst_b, .instr_valid, .instr, .core_id,
    .jump_register_set_0(jr0), .jump_register_set_1(jr1), .flags(v[35:20]),
    .terminal_count(v[3:0]), .start_in(v[4]), .shortcut_drain_source(v[7:5]),
    .shortcut_source(v[10:8]), .alu_done(v[11]), .boost_voltage_high(v[12]),
    .current_feedback(v[18:13]), .own_current_feedback(v[19]),
    .program_counter, .jump_taken);
  // ****************************
  // clock and watchdog
  // ****************************
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ceiling well above the ~2500 cycles the scenarios need
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      final_report();
    end
  end
  // ****************************
  // reference and checks
  // ****************************
  // expected condition for a code, from the current levels in v
  function automatic logic cond(input logic [5:0] c);
    int i;
    i = c;
    if (i < 16) return !v[20 + i];
    if (i < 32) return v[i + 4];
    if (i < 36) return v[i - 32];
    if (i < 38) return v[4] ^ (i == 36);
    if (i < 44) return !v[i - 33];
    if (i < 47) return v[i - 39];
    if (i == 47) return v[11];
    if (i < 50) return v[12] ^ (i == 49);
    if (i < 56) return v[i - 37];
    if (i < 62) return !v[i - 43];
    return v[19] ^ (i == 63);
  endfunction : cond
  task chk_pc(input logic [9:0] e);
    n_compared++;
    if (program_counter !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t pc %h exp %h", $time, program_counter, e);
    end
  endtask : chk_pc
  task chk_bit(input logic a, input logic e);
    n_compared++;
    if (a !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t jump_taken %b exp %b", $time, a, e);
    end
  endtask : chk_bit
  // executes one word; valid stays high so words run back to back
  task step(input logic [15:0] w, input logic tk);
    logic [9:0] e;
    e = mpc + 10'h001;
    if (tk && w[15:11] == 5'h00)
      e = mpc + {{5{w[4]}}, w[4:0]};
    else if (tk)
      e = w[3] ? jr1 : jr0;
    instr = w;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    chk_pc(e);
    chk_bit(jump_taken, tk);
    mpc = e;
  endtask : step
  // ****************************
  // scenarios
  // ****************************
  // walking one over every level, then all low and all high
  task t_cond;
    for (int p = 0; p < 38; p++)
    begin
      v = (p < 36) ? 36'h1 << p : {36{p[0]}};
      for (int c = 0; c < 64; c++)
        step({5'h00, c[5:0], c[4:0] ^ p[4:0]},
             cond(c[5:0]));
    end
    $display("test cond done");
  endtask : t_cond
  task t_abs;
    for (int k = 0; k < 8; k++)
    begin
      core_id = k[2];
      step(16'h3985 | {11'h000, k[0], k[1], 3'h0},
           k[0] == k[2]);
    end
    $display("test abs done");
  endtask : t_abs
  // near-miss encodings and idle cycles must not jump; a flag-high relative word still jumps
  task t_other;
    step(16'h0800, 1'b0);
    step(16'h39a5, 1'b0);
    step(16'h3984, 1'b0);
    step(16'h0203, cond(6'h10));
    // reset in mid-run must clear pc and a pending jump marker at once
    instr_valid = 1'b0;
    rst_b = 1'b0;
    @(negedge clk_sys);
    chk_pc(10'h000);
    chk_bit(jump_taken, 1'b0);
    rst_b = 1'b1;
    mpc = 10'h000;
    // two idle edges so the idle hold is seen to complete
    repeat (2) @(negedge clk_sys);
    chk_pc(mpc);
    chk_bit(jump_taken, 1'b0);
    $display("test other done");
  endtask : t_other
  task final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    {rst_b, instr_valid, core_id, instr, v} = '0;
    jr0 = 10'h3ff;
    jr1 = 10'h2a5;
    mpc = 10'h000;
    // seventeen falling edges put seventeen rising edges under reset
    repeat (17) @(negedge clk_sys);
    rst_b = 1'b1;
    chk_pc(10'h000);
    chk_bit(jump_taken, 1'b0);
    t_cond();
    t_abs();
    t_other();
    final_report();
  end
endmodule : mcjd_tb_top
